// ===== hw/ebt_break_trace.v
// break and trace logic with an axi4-lite register slave
`timescale 1ns/1ns
// How it works
// - halt when pc falls within armed break range
// - address halt only after instruction completes
// - trace-full break halts after 8k captures
// - pass counter steers break or trace
// - pass count zero on break halts
// - stack overflow halts when enabled
// - watchdog reset halts when enabled
// - host halt stops processor any time
// - 8k buffer records address and opcode
// - wrap overwriting oldest unless trace-full break
// - entry holds address, opcode, stamp, changes
// - halt trace freezes, second request resumes
// - stamp is stopwatch; clearing resets it
// - 16-bit counter decrements on range match
// - pass-on-break halts on any break too
// - break and pass ranges checked independently
// - pass-on-trace captures only after zero
module ebt_break_trace (
  aclk,
  aresetn,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  core_pc,
  core_opcode,
  core_chg,
  core_exec_done,
  core_stack_ovf,
  core_wdt_reset,
  core_halt
);
  `include "ebt_regs.vh"
  input wire aclk; // 100 mhz clock
  input wire aresetn; // synchronous reset, active low
  input wire [7:0] s_axi_awaddr; // write address
  input wire s_axi_awvalid;
  output reg s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output reg s_axi_wready;
  output reg [1:0] s_axi_bresp;
  output reg s_axi_bvalid;
  input wire s_axi_bready;
  input wire [7:0] s_axi_araddr; // read address
  input wire s_axi_arvalid;
  output reg s_axi_arready;
  output reg [31:0] s_axi_rdata;
  output reg [1:0] s_axi_rresp;
  output reg s_axi_rvalid;
  input wire s_axi_rready;
  input wire [15:0] core_pc; // address of executed instruction
  input wire [15:0] core_opcode; // opcode or data of that cycle
  input wire [15:0] core_chg; // changed-register info of that cycle
  input wire core_exec_done; // one-cycle pulse: instruction completed
  input wire core_stack_ovf; // pulse: hardware stack overflowed
  input wire core_wdt_reset; // pulse: watchdog time-out reset
  output reg core_halt; // level: processor held in halt

  //////////////////////////////////////////////////////////////////////
  // functions
  // inclusive range test, used for break and pass ranges
  function in_range;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // byte-lane merge of a write into a 16-bit field; upper lanes unused
  function [15:0] merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] st;
    begin
      merge = old;
      if (st[0]) begin
        merge[7:0] = wd[7:0];
      end
      if (st[1]) begin
        merge[15:8] = wd[15:8];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////
  // registers
  reg [5:0] ctrl_reg; // option enables
  reg [15:0] brk_lo_reg; // break range start
  reg [15:0] brk_hi_reg; // break range stop
  reg [15:0] pc_lo_reg; // pass range start
  reg [15:0] pc_hi_reg; // pass range stop
  reg [15:0] pass_reg; // pass counter
  reg pzero_reg; // counter has reached zero
  reg frozen_reg; // trace capture frozen
  reg [12:0] wptr_reg; // next trace slot
  reg [13:0] count_reg; // entries captured, saturates at 8k
  reg [31:0] tstamp_reg; // stopwatch cycle count
  reg [12:0] rdidx_reg; // trace slot selected for reading
  reg [2:0] cause_reg; // why the last halt happened
  reg [7:0] awaddr_reg; // latched write address
  reg aw_have_reg; // write address held
  reg [31:0] wdata_reg; // latched write data
  reg [3:0] wstrb_reg;
  reg w_have_reg; // write data held

  wire [63:0] trc_rd; // entry at rdidx
  wire wr_fire; // write performs this cycle
  wire [31:0] cmd_w; // command word of this write
  wire is_cmd;
  wire is_pass;
  wire brk_hit;
  wire pass_hit;
  wire cap_ok;
  wire cap_en;
  wire full_now;
  reg halt_set;
  reg [2:0] halt_cause;

  //////////////////////////////////////////////////////////////////////
  // write channel: address and data in either order
  assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign cmd_w = {16'h0000, merge(16'h0000, wdata_reg, wstrb_reg)};
  assign is_cmd = wr_fire && (awaddr_reg == `EBT_CMD_OFF);
  assign is_pass = wr_fire && (awaddr_reg == `EBT_PASS_OFF);

  // handshakes of the write path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready;
      s_axi_wready <= !w_have_reg && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        // unmapped or read-only offsets answer slverr
        case (awaddr_reg)
          `EBT_CTRL_OFF, `EBT_BRK_LO_OFF, `EBT_BRK_HI_OFF,
          `EBT_PC_LO_OFF, `EBT_PC_HI_OFF, `EBT_PASS_OFF,
          `EBT_CMD_OFF, `EBT_RDIDX_OFF: s_axi_bresp <= 2'h0;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end
    end
  end

  // configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `EBT_CTRL_RST;
      brk_lo_reg <= 16'hffff;
      brk_hi_reg <= 16'h0000;
      pc_lo_reg <= 16'hffff;
      pc_hi_reg <= 16'h0000;
      rdidx_reg <= 13'h0000;
    end else if (wr_fire) begin
      case (awaddr_reg)
        `EBT_CTRL_OFF: ctrl_reg <= wstrb_reg[0] ? wdata_reg[5:0] : ctrl_reg;
        `EBT_BRK_LO_OFF: brk_lo_reg <= merge(brk_lo_reg, wdata_reg, wstrb_reg);
        `EBT_BRK_HI_OFF: brk_hi_reg <= merge(brk_hi_reg, wdata_reg, wstrb_reg);
        `EBT_PC_LO_OFF: pc_lo_reg <= merge(pc_lo_reg, wdata_reg, wstrb_reg);
        `EBT_PC_HI_OFF: pc_hi_reg <= merge(pc_hi_reg, wdata_reg, wstrb_reg);
        `EBT_RDIDX_OFF: begin
          rdidx_reg[7:0] <= wstrb_reg[0] ? wdata_reg[7:0] : rdidx_reg[7:0];
          rdidx_reg[12:8] <= wstrb_reg[1] ? wdata_reg[12:8] : rdidx_reg[12:8];
        end
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // match logic, sampled on completed instructions only
  // each range is tested on its own, neither gates the other
  assign brk_hit = core_exec_done && ctrl_reg[`EBT_C_BRK_EN] &&
    in_range(core_pc, brk_lo_reg, brk_hi_reg);
  assign pass_hit = core_exec_done && ctrl_reg[`EBT_C_PASS_EN] &&
    in_range(core_pc, pc_lo_reg, pc_hi_reg);

  // pass counter: host load while halted, decrement, hold at zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      pass_reg <= `EBT_PASS_RST;
      pzero_reg <= 1'b0;
    end else if (is_pass && core_halt) begin
      // loads while running are ignored
      pass_reg <= merge(pass_reg, wdata_reg, wstrb_reg);
      pzero_reg <= 1'b0;
    end else if (pass_hit && !core_halt && !pzero_reg) begin
      if (pass_reg != 16'h0000) begin
        pass_reg <= pass_reg - 16'h0001;
      end
      if (pass_reg <= 16'h0001) begin
        pzero_reg <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // trace capture
  // pass-on-trace holds capture off until the counter is at zero
  assign cap_ok = !ctrl_reg[`EBT_C_PASS_TRC] || pzero_reg;
  assign full_now = count_reg[13];
  assign cap_en = core_exec_done && !core_halt && !frozen_reg && cap_ok &&
    !(ctrl_reg[`EBT_C_TFULL] && full_now);

  ebt_trace_mem u_mem (
    .aclk(aclk),
    .wr_en(cap_en),
    .wr_idx(wptr_reg),
    // address, opcode/data, stamp and changed info
    .wr_data({core_chg, tstamp_reg[15:0], core_opcode, core_pc}),
    .rd_idx(rdidx_reg),
    .rd_data(trc_rd)
  );

  // write pointer wraps, overwriting the oldest slot
  always @(posedge aclk) begin
    if (!aresetn || (is_cmd && cmd_w[`EBT_K_TRC_CLR])) begin
      wptr_reg <= 13'h0000;
      count_reg <= 14'h0000;
    end else if (cap_en) begin
      wptr_reg <= wptr_reg + 13'h0001;
      if (!full_now) begin
        count_reg <= count_reg + 14'h0001;
      end
    end
  end

  // freeze toggles on each halt-trace command
  always @(posedge aclk) begin
    if (!aresetn) begin
      frozen_reg <= 1'b0;
    end else if (is_cmd && cmd_w[`EBT_K_TRC_TOG]) begin
      frozen_reg <= !frozen_reg;
    end
  end

  // stopwatch, counts while running, cleared by command
  always @(posedge aclk) begin
    if (!aresetn || (is_cmd && cmd_w[`EBT_K_SW_CLR])) begin
      tstamp_reg <= 32'h0000_0000;
    end else if (!core_halt) begin
      tstamp_reg <= tstamp_reg + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // halt sources in priority order
  always @* begin
    halt_set = 1'b1;
    halt_cause = `EBT_CS_NONE;
    if (is_cmd && cmd_w[`EBT_K_HALT]) begin
      halt_cause = `EBT_CS_USER;
    end else if (brk_hit) begin
      halt_cause = `EBT_CS_ADDR;
    end else if (ctrl_reg[`EBT_C_STK] && core_stack_ovf) begin
      halt_cause = `EBT_CS_STK;
    end else if (ctrl_reg[`EBT_C_WDT] && core_wdt_reset) begin
      halt_cause = `EBT_CS_WDT;
    end else if (cap_en && ctrl_reg[`EBT_C_TFULL] &&
                 count_reg == 14'h1fff) begin
      halt_cause = `EBT_CS_FULL;
    end else if (pass_hit && !ctrl_reg[`EBT_C_PASS_TRC] && !pzero_reg &&
                 pass_reg <= 16'h0001) begin
      halt_cause = `EBT_CS_PASS;
    end else begin
      halt_set = 1'b0;
    end
  end

  // halt flag: any source sets, run command clears; a set wins while running, a host halt wins always
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_halt <= 1'b0;
      cause_reg <= `EBT_CS_NONE;
    end else if (halt_set && (!core_halt || halt_cause == `EBT_CS_USER)) begin
      core_halt <= 1'b1;
      cause_reg <= halt_cause;
    end else if (is_cmd && cmd_w[`EBT_K_RUN]) begin
      core_halt <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read channel, one cycle after address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (s_axi_araddr)
          `EBT_CTRL_OFF: s_axi_rdata <= {26'h0, ctrl_reg};
          `EBT_STAT_OFF: s_axi_rdata <= {25'h0, cause_reg, pzero_reg,
            full_now, frozen_reg, core_halt};
          `EBT_BRK_LO_OFF: s_axi_rdata <= {16'h0, brk_lo_reg};
          `EBT_BRK_HI_OFF: s_axi_rdata <= {16'h0, brk_hi_reg};
          `EBT_PC_LO_OFF: s_axi_rdata <= {16'h0, pc_lo_reg};
          `EBT_PC_HI_OFF: s_axi_rdata <= {16'h0, pc_hi_reg};
          `EBT_PASS_OFF: s_axi_rdata <= {16'h0, pass_reg};
          `EBT_CMD_OFF: s_axi_rdata <= 32'h0000_0000;
          `EBT_RDIDX_OFF: s_axi_rdata <= {19'h0, rdidx_reg};
          `EBT_RDADDR_OFF: s_axi_rdata <= trc_rd[31:0];
          `EBT_RDTS_OFF: s_axi_rdata <= trc_rd[63:32];
          `EBT_TSTAMP_OFF: s_axi_rdata <= tstamp_reg;
          `EBT_WRPTR_OFF: s_axi_rdata <= {19'h0, wptr_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // ebt_break_trace

// ===== hw/ebt_regs.vh
// register offsets, field positions, reset values and sizes of the break/trace block
`ifndef EBT_REGS_VH
`define EBT_REGS_VH
// register byte offsets
`define EBT_CTRL_OFF 8'h00
`define EBT_STAT_OFF 8'h04
`define EBT_BRK_LO_OFF 8'h08
`define EBT_BRK_HI_OFF 8'h0c
`define EBT_PC_LO_OFF 8'h10
`define EBT_PC_HI_OFF 8'h14
`define EBT_PASS_OFF 8'h18
`define EBT_CMD_OFF 8'h1c
`define EBT_RDIDX_OFF 8'h20
`define EBT_RDADDR_OFF 8'h24
`define EBT_RDTS_OFF 8'h28
`define EBT_TSTAMP_OFF 8'h2c
`define EBT_WRPTR_OFF 8'h30
// control field positions
`define EBT_C_BRK_EN 0
`define EBT_C_TFULL 1
`define EBT_C_PASS_TRC 2
`define EBT_C_STK 3
`define EBT_C_WDT 4
`define EBT_C_PASS_EN 5
// command bits (write one to act)
`define EBT_K_HALT 0
`define EBT_K_RUN 1
`define EBT_K_TRC_TOG 2
`define EBT_K_SW_CLR 3
`define EBT_K_TRC_CLR 4
// status field positions
`define EBT_S_HALT 0
`define EBT_S_FROZEN 1
`define EBT_S_FULL 2
`define EBT_S_PZERO 3
`define EBT_S_CAUSE 4
// halt cause codes
`define EBT_CS_NONE 3'h0
`define EBT_CS_ADDR 3'h1
`define EBT_CS_FULL 3'h2
`define EBT_CS_PASS 3'h3
`define EBT_CS_STK 3'h4
`define EBT_CS_WDT 3'h5
`define EBT_CS_USER 3'h6
// reset values
`define EBT_CTRL_RST 6'h00
`define EBT_PASS_RST 16'h0000
// trace buffer depth: 8K entries
`define EBT_DEPTH 8192
`define EBT_AW 13
`endif

// ===== hw/ebt_trace_mem.v
// trace buffer storage: 8k entries of address, opcode, time stamp and changed info
`timescale 1ns/1ns
module ebt_trace_mem (
  aclk,
  wr_en,
  wr_idx,
  wr_data,
  rd_idx,
  rd_data
);
  `include "ebt_regs.vh"
  input wire aclk; // system clock
  input wire wr_en; // store one entry
  input wire [12:0] wr_idx; // slot written
  input wire [63:0] wr_data; // {changes, stamp, opcode, address}
  input wire [12:0] rd_idx; // slot read
  output reg [63:0] rd_data; // registered read data

  reg [63:0] mem [0:`EBT_DEPTH-1]; // entry storage

  // write port and registered read port
  always @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule // ebt_trace_mem

// ===== verif/ebt_break_trace_chk.sv
// port checker for the break and trace block
`timescale 1ns/1ns
module ebt_break_trace_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire core_exec_done,
  input wire core_stack_ovf,
  input wire core_wdt_reset,
  input wire core_halt
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // one address or data item taken
  sequence s_aw;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_w;
    s_axi_wvalid && s_axi_wready;
  endsequence
  // a response still waiting for its ready
  sequence s_bwait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_aw_once: assert property (s_aw |=> !s_axi_awready)
    else $error("write address ready stayed high");
  a_w_once: assert property (s_w |=> !s_axi_wready)
    else $error("write data ready stayed high");
  a_b_stands: assert property (s_bwait |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken during response");
  a_r_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data not held");
  a_ar_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  a_halt_cause: assert property ($rose(core_halt) |->
    $past(core_exec_done || core_stack_ovf || core_wdt_reset) ||
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_wvalid))
    else $error("halt without a cause");
  a_run_cause: assert property ($fell(core_halt) |->
    s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("halt released without a command");
endmodule // ebt_break_trace_chk
bind ebt_break_trace ebt_break_trace_chk chk_i (.*);

// ===== verif/ebt_break_trace_test.sv
// register-level testbench for the break and trace block
`timescale 1ns/1ns
`include "ebt_regs.vh"
module ebt_break_trace_test;
  reg aclk, aresetn, awvalid, wvalid, arvalid;
  reg run_en, slow, load, ovf_req, wdt_req, bready, rready;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, d, w;
  reg [15:0] pc_init;
  reg [1:0] br, rr;
  wire awready, wready, bvalid, arready, rvalid, cdone, covf, cwdt, halt;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] cpc, cop, cchg, pc_now;
  integer fails, checks_done, i;
  ebt_break_trace uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .core_pc(cpc),
    .core_opcode(cop), .core_chg(cchg), .core_exec_done(cdone),
    .core_stack_ovf(covf), .core_wdt_reset(cwdt), .core_halt(halt));
  ebt_core_model core_i (.aclk(aclk), .core_halt(halt), .run_en(run_en),
    .slow(slow), .load(load), .pc_init(pc_init), .ovf_req(ovf_req),
    .wdt_req(wdt_req), .core_pc(cpc), .core_opcode(cop), .core_chg(cchg),
    .core_exec_done(cdone), .core_stack_ovf(covf), .core_wdt_reset(cwdt),
    .pc_now(pc_now));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task ck(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tout;
    begin
      fails = fails + 1;
      $display("timeout at %0t", $time);
      tally_and_finish;
    end
  endtask
  // axi write: both items offered together, response caught
  task wr(input [7:0] a, input [31:0] v);
    integer n;
    begin
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      n = 0;
      while (n >= 0 && n < 40) begin
        @(posedge aclk);
        n = n + 1;
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        // ready is raised late so the response must wait for it
        if (bvalid && bready) begin
          br = bresp;
          bready <= 1'b0;
          n = -1;
        end else if (bvalid) begin
          bready <= 1'b1;
        end
      end
      if (n == 40) tout;
    end
  endtask
  // axi read into d and rr
  task rd(input [7:0] a);
    integer n;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      n = 0;
      while (n >= 0 && n < 40) begin
        @(posedge aclk);
        n = n + 1;
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid && rready) begin
          d = rdata;
          rr = rresp;
          rready <= 1'b0;
          n = -1;
        end else if (rvalid) begin
          rready <= 1'b1;
        end
      end
      if (n == 40) tout;
    end
  endtask
  // wait for the halt, then check status and cause
  task hw(input [2:0] cs);
    integer n;
    begin
      n = 0;
      while (halt !== 1'b1 && n < 9000) begin
        @(posedge aclk);
        n = n + 1;
      end
      if (n == 9000) tout;
      rd(`EBT_STAT_OFF);
      ck(d & 32'h71, {25'h0, cs, 4'h1});
    end
  endtask
  task ld(input [15:0] v);
    begin
      pc_init <= v;
      load <= 1'b1;
      @(posedge aclk);
      load <= 1'b0;
    end
  endtask
  task pulse(input integer k);
    begin
      if (k == 0) ovf_req <= 1'b1;
      else wdt_req <= 1'b1;
      @(posedge aclk);
      ovf_req <= 1'b0;
      wdt_req <= 1'b0;
    end
  endtask
  task entry(input [31:0] idx);
    begin
      wr(`EBT_RDIDX_OFF, idx);
      repeat (2) @(posedge aclk);
      rd(`EBT_RDADDR_OFF);
    end
  endtask
  initial begin
    fails = 0;
    checks_done = 0;
    {aresetn, awvalid, wvalid, arvalid, slow, ovf_req, wdt_req} = 7'h00;
    {bready, rready} = 2'h0;
    {awaddr, araddr, wdata, pc_init} = 64'h0;
    run_en = 1'b1;
    load = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    load <= 1'b0;
    @(posedge aclk);
    rd(`EBT_CTRL_OFF);
    ck(d, 32'h0);
    rd(`EBT_PASS_OFF);
    ck(d, 32'h0);
    rd(8'h3c);
    ck(rr, 2);
    wr(`EBT_STAT_OFF, 32'h5);
    ck(br, 2);
    wr(`EBT_CMD_OFF, 32'h1);
    hw(3'h6);
    $display("test reset done");
    wr(`EBT_BRK_LO_OFF, 32'h5a);
    wr(`EBT_BRK_HI_OFF, 32'h5a);
    wr(`EBT_CTRL_OFF, 32'h1);
    wr(`EBT_CMD_OFF, 32'h18);
    ld(16'h50);
    wr(`EBT_CMD_OFF, 32'h2);
    hw(3'h1);
    ck(pc_now, 16'h5b);
    rd(`EBT_WRPTR_OFF);
    ck(d, 32'd11);
    entry(32'd10);
    ck(d, 32'h3c66005a);
    rd(`EBT_RDTS_OFF);
    ck(d[31:16], 16'h5b);
    ck(d[15:0], 16'ha);
    wr(`EBT_CMD_OFF, 32'h8);
    rd(`EBT_TSTAMP_OFF);
    ck(d, 32'h0);
    $display("test address done");
    for (i = 0; i < 2; i = i + 1) begin
      wr(`EBT_CTRL_OFF, 32'h0);
      wr(`EBT_CMD_OFF, 32'h2);
      pulse(i);
      repeat (4) @(posedge aclk);
      ck(halt, 0);
      wr(`EBT_CTRL_OFF, 32'h8 << i);
      pulse(i);
      hw(3'h4 + i[2:0]);
    end
    $display("test events done");
    wr(`EBT_PC_LO_OFF, 32'h70);
    wr(`EBT_PC_HI_OFF, 32'h72);
    wr(`EBT_PASS_OFF, 32'h3);
    wr(`EBT_CTRL_OFF, 32'h21);
    ld(16'h6e);
    wr(`EBT_CMD_OFF, 32'h2);
    hw(3'h3);
    ck(pc_now, 16'h73);
    rd(`EBT_PASS_OFF);
    ck(d, 32'h0);
    wr(`EBT_BRK_LO_OFF, 32'h75);
    wr(`EBT_BRK_HI_OFF, 32'h75);
    wr(`EBT_PASS_OFF, 32'h5);
    wr(`EBT_CMD_OFF, 32'h2);
    hw(3'h1);
    ck(pc_now, 16'h76);
    rd(`EBT_PASS_OFF);
    ck(d, 32'h5);
    $display("test pass break done");
    wr(`EBT_CMD_OFF, 32'h10);
    wr(`EBT_PC_LO_OFF, 32'h80);
    wr(`EBT_PC_HI_OFF, 32'h80);
    wr(`EBT_PASS_OFF, 32'h1);
    wr(`EBT_CTRL_OFF, 32'h24);
    ld(16'h7c);
    wr(`EBT_CMD_OFF, 32'h2);
    repeat (20) @(posedge aclk);
    wr(`EBT_CMD_OFF, 32'h1);
    hw(3'h6);
    rd(`EBT_WRPTR_OFF);
    w = d;
    ck(w, pc_now - 16'h81);
    entry(w - 1);
    ck(d[15:0], pc_now - 16'h1);
    $display("test pass trace done");
    wr(`EBT_CTRL_OFF, 32'h0);
    wr(`EBT_CMD_OFF, 32'h2);
    wr(`EBT_CMD_OFF, 32'h4);
    rd(`EBT_WRPTR_OFF);
    w = d;
    repeat (10) @(posedge aclk);
    rd(`EBT_WRPTR_OFF);
    ck(d, w);
    wr(`EBT_CMD_OFF, 32'h4);
    repeat (10) @(posedge aclk);
    rd(`EBT_WRPTR_OFF);
    ck(d > w, 1);
    $display("test freeze done");
    wr(`EBT_CMD_OFF, 32'h1);
    hw(3'h6);
    wr(`EBT_CMD_OFF, 32'h10);
    wr(`EBT_CTRL_OFF, 32'h2);
    ld(16'h0);
    wr(`EBT_CMD_OFF, 32'h2);
    hw(3'h2);
    ck(pc_now, 16'h2000);
    rd(`EBT_STAT_OFF);
    ck(d[2], 1);
    wr(`EBT_CTRL_OFF, 32'h0);
    slow <= 1'b1;
    wr(`EBT_CMD_OFF, 32'h2);
    repeat (10) @(posedge aclk);
    wr(`EBT_CMD_OFF, 32'h1);
    hw(3'h6);
    entry(32'h0);
    ck(d[15:0], 16'h2000);
    $display("test full done");
    tally_and_finish;
  end
endmodule // ebt_break_trace_test

// ===== verif/ebt_core_model.sv
// behavioural model of the observed target core
`timescale 1ns/1ns
module ebt_core_model (
  input wire aclk,
  input wire core_halt,
  input wire run_en,
  input wire slow,
  input wire load,
  input wire [15:0] pc_init,
  input wire ovf_req,
  input wire wdt_req,
  output wire [15:0] core_pc,
  output wire [15:0] core_opcode,
  output wire [15:0] core_chg,
  output wire core_exec_done,
  output wire core_stack_ovf,
  output wire core_wdt_reset,
  output reg [15:0] pc_now
);
  reg ph_reg;
  // a halted core executes nothing and raises no event
  wire go = run_en && !core_halt && (!slow || ph_reg);
  assign core_exec_done = go;
  // outside the pulse the pc and change buses show the inverse, the opcode bus shows pc_now
  assign core_pc = go ? pc_now : ~pc_now;
  assign core_opcode = go ? pc_now ^ 16'h3c3c : pc_now;
  assign core_chg = go ? pc_now + 16'h0001 : ~pc_now;
  assign core_stack_ovf = ovf_req && !core_halt;
  assign core_wdt_reset = wdt_req && !core_halt;
  // program counter steps once per completed instruction
  always @(posedge aclk) begin
    if (load) begin
      pc_now <= pc_init;
      ph_reg <= 1'b0;
    end else begin
      ph_reg <= ~ph_reg;
      if (go) begin
        pc_now <= pc_now + 16'h0001;
      end
    end
  end
endmodule // ebt_core_model
